// ==== bench/wdt_key_guard_tb.sv ====
// Purpose: Self-checking bench for the watchdog with key guard.
// Assumes: Short tick and soft delay parameters; APB answers with zero wait.
// Notes: Expiry windows allow for tick phase and pipeline stages.
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_with_key_guard_tb_top;
  import wdt_pkg::*;
  localparam int TICKS = 4;
  localparam int SDLY = 8;
  localparam int LIMIT = 30000;
  logic core_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cpu_events_s ev;
  wdt_actions_s act;
  logic exp_flag;
  logic pd_flag;
  logic irq;
  logic [31:0] rd;
  logic err;
  int num_errors;
  int checked;
  int cycles;
  int resets;
  int n;
  int e;
  int r0;

  wdt_key_guard #(.SOFT_DELAY(SDLY), .TICK_CYCLES(TICKS)) u_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cpu_events(ev),
    .actions(act),
    .watchdog_expiry_flag(exp_flag),
    .powerdown_flag(pd_flag),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Counts cycles for the hang limit and counts device reset cycles.
  always @(posedge core_clk)
  begin
    cycles++;
    if (act.device_reset === 1'b1)
      resets++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      $display("mismatch at %0t: cycle limit reached", $time);
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string msg);
    checked++;
    if (got !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, want);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pulses the halt and clear instruction bits, keeping the low-power level.
  task automatic pulse(input logic [1:0] bits);
    @(posedge core_clk);
    ev <= {bits, ev.low_power};
    @(posedge core_clk);
    ev <= {2'b00, ev.low_power};
  endtask : pulse

  task automatic wait_act(input int idx, input int maxc);
    n = 0;
    while (act[idx] !== 1'b1 && n < maxc)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_act

  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ev = 3'h0;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    resets = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
    chk(rd, {24'h00_0000, CONFIG_RESET}, "config reset");
    apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "cause reset");
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    $display("test reset done");

    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, ADDR_CONFIG, {24'h00_0000, KEY_ENABLE, s[2:0]});
      pulse(2'b01);
      wait_act(2, 6000);
      e = (256 << (2 * s)) * TICKS;
      chk({31'h0, n >= e - 8 && n <= e + 8}, 32'h0000_0001, "expiry time");
      repeat (3) @(posedge core_clk);
      chk({31'h0, exp_flag}, 32'h0000_0001, "expiry flag");
      chk({31'h0, irq}, 32'h0000_0001, "irq on expiry");
      apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0007);
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    end
    $display("test expiry done");

    r0 = resets;
    // Eight services span more than one timeout, so a lost clear would show.
    repeat (8)
    begin
      repeat (700) @(posedge core_clk);
      pulse(2'b01);
    end
    chk(resets, r0, "serviced watchdog reset");
    apb(1'b1, ADDR_CONFIG, {24'h00_0000, KEY_DISABLE, 3'h0});
    repeat (2000) @(posedge core_clk);
    chk(resets, r0, "disabled watchdog reset");
    $display("test service done");

    apb(1'b1, ADDR_CONFIG, {24'h00_0000, KEY_ENABLE, 3'h0});
    pulse(2'b10);
    @(posedge core_clk);
    ev.low_power <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({30'h0, pd_flag, exp_flag}, 32'h0000_0002, "halt flags");
    wait_act(1, 2000);
    chk({31'h0, n >= 1008 && n <= 1032}, 32'h0000_0001, "wake time");
    chk({31'h0, act.pc_sp_reset}, 32'h0000_0001, "pc sp reset");
    repeat (3) @(posedge core_clk);
    chk({30'h0, pd_flag, exp_flag}, 32'h0000_0003, "wake flags");
    chk(resets, r0, "no device reset on wake");
    ev.low_power <= 1'b0;
    pulse(2'b01);
    repeat (3) @(posedge core_clk);
    chk({31'h0, pd_flag}, 32'h0000_0000, "powerdown cleared");
    $display("test low power done");

    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0007);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, ADDR_CONFIG, {24'h00_0000, 5'h1F, 3'h0});
    apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "key fault cause");
    wait_act(2, 100);
    chk({31'h0, n + 3 >= SDLY && n + 3 <= SDLY + 8}, 32'h0000_0001, "soft delay");
    repeat (8) @(posedge core_clk);
    apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
    chk(rd, {24'h00_0000, CONFIG_RESET}, "config after fault");
    apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "cause kept");
    chk({31'h0, irq}, 32'h0000_0000, "masked irq");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0004);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0000_0001, "unmasked irq");
    apb(1'b1, ADDR_CAUSE, 32'h0000_0001);
    apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "cause write one");
    apb(1'b1, ADDR_CAUSE, 32'h0000_0000);
    apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "cause write zero");
    apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0004);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq w1c");
    $display("test key fault done");
    test_done();
  end
endmodule : watchdog_timer_with_key_guard_tb_top
`default_nettype wire

// ==== inc/wdt_pkg.sv ====
// Purpose: Shared constants and types for the watchdog timer with key guard.
// Assumes: APB slave with 32-bit data; core clock 50 MHz.
// Notes: Register layout, reset values and timing counts live here.
package wdt_pkg;

  localparam int unsigned CORE_CLK_HZ = 50_000_000;
  localparam int unsigned LOW_SPEED_HZ = 32_000;
  // Low-speed tick period in core cycles, rounded down.
  localparam int unsigned LS_TICK_CYCLES = CORE_CLK_HZ / LOW_SPEED_HZ;
  localparam int unsigned SOFT_RESET_DELAY_US = 16;
  localparam int unsigned SOFT_RESET_DELAY_CYCLES =
    (SOFT_RESET_DELAY_US * (CORE_CLK_HZ / 1_000_000));
  localparam int unsigned RESET_PULSE_CYCLES = 4;

  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_CAUSE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [2:0] TSEL_RESET = 3'h3;
  localparam logic [7:0] CONFIG_RESET = {KEY_ENABLE, TSEL_RESET};
  localparam int unsigned KEY_LSB = 3;
  localparam int unsigned KEY_FAULT_BIT = 0;

  localparam int unsigned IRQ_BITS = 3;
  localparam int unsigned IRQ_EXPIRY = 0;
  localparam int unsigned IRQ_WAKE = 1;
  localparam int unsigned IRQ_KEY_FAULT = 2;

  typedef struct packed {
    logic halt_instr;
    logic watchdog_clear_instr;
    logic low_power;
  } cpu_events_s;

  typedef struct packed {
    logic device_reset;
    logic wake;
    logic pc_sp_reset;
  } wdt_actions_s;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_WAIT = 2'b01,
    KEY_FIRE = 2'b11
  } key_state_e;

endpackage : wdt_pkg

// ==== verilog/wdt_key_guard.sv ====
// Purpose: Watchdog with key guard, reset-cause flag and APB registers.
// Assumes: rst_n is the power-on reset; warm resets leave this block alone.
// Notes: device_reset is a pulse the system reset controller acts on.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1: Count low-speed ticks, power-of-two timeout.
// RULE2: Select code picks ratio 2^8 to 2^18.
// RULE3: Key 01010 enables, 10101 disables, else reset.
// RULE4: Invalid key sets key-fault cause bit 0.
// RULE5: Cause flag cleared only by software zero.
// RULE6: Power-on key 01010, select 011.
// RULE7: Running expiry resets device, sets expiry flag.
// RULE8: Low-power expiry wakes, resets PC and SP.
// RULE9: Invalid key, clear or halt clears count.
// RULE10: Halt sets power-down; clear instruction clears it.
// RULE11: Software clears watchdog before the timeout.
// RULE12: Low-power entry clears count and expiry flag.
// RULE13: Cause flag survives the reset it causes.
// RULE14: Disabled watchdog holds count at zero.
module wdt_key_guard #(
  parameter int unsigned SOFT_DELAY = wdt_pkg::SOFT_RESET_DELAY_CYCLES,
  parameter int unsigned TICK_CYCLES = wdt_pkg::LS_TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdt_pkg::cpu_events_s cpu_events,
  output wdt_pkg::wdt_actions_s actions,
  output logic watchdog_expiry_flag,
  output logic powerdown_flag,
  output logic irq
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic [7:0] watchdog_config;
  logic [7:0] reset_cause_flags;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] irq_mask;
  logic wr_access;
  logic wr_config;
  logic wr_cause;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic addr_ok;
  logic [31:0] next_rdata;

  assign wr_access = psel && penable && pwrite;
  assign wr_config = wr_access && (paddr == ADDR_CONFIG);
  assign wr_cause = wr_access && (paddr == ADDR_CAUSE);
  assign wr_irq_stat = wr_access && (paddr == ADDR_IRQ_STAT);
  assign wr_irq_mask = wr_access && (paddr == ADDR_IRQ_MASK);
  assign addr_ok = (paddr == ADDR_CONFIG) || (paddr == ADDR_CAUSE) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT) ||
                   (paddr == ADDR_IRQ_MASK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign next_rdata = (paddr == ADDR_CONFIG) ? {24'h00_0000, watchdog_config} :
                      (paddr == ADDR_CAUSE) ? {24'h00_0000, reset_cause_flags} :
                      (paddr == ADDR_STATUS) ?
                        {30'h0000_0000, powerdown_flag, watchdog_expiry_flag} :
                      (paddr == ADDR_IRQ_STAT) ? {29'h0000_0000, irq_stat} :
                      (paddr == ADDR_IRQ_MASK) ? {29'h0000_0000, irq_mask} :
                      32'h0000_0000;

  // Read data is registered in the setup cycle for a zero-wait access.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Key decode and soft-reset delay.
  logic [4:0] watchdog_key_field;
  logic [2:0] timeout_select;
  logic key_valid;
  logic key_enabled;
  logic bad_key_write;
  logic fault_event;
  key_state_e key_state;
  logic [15:0] delay_count;
  logic [2:0] pulse_count;

  assign watchdog_key_field = watchdog_config[7:KEY_LSB];
  assign timeout_select = watchdog_config[2:0];
  assign key_valid = (watchdog_key_field == KEY_ENABLE) ||
                     (watchdog_key_field == KEY_DISABLE);
  assign key_enabled = (watchdog_key_field == KEY_ENABLE); // see RULE3
  assign bad_key_write = wr_config && (pwdata[7:KEY_LSB] != KEY_ENABLE) &&
                         (pwdata[7:KEY_LSB] != KEY_DISABLE);
  assign fault_event = (key_state == KEY_IDLE) && !key_valid;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      watchdog_config <= CONFIG_RESET; // see RULE6
    else if (key_state == KEY_FIRE && pulse_count == 3'(RESET_PULSE_CYCLES - 1))
      watchdog_config <= CONFIG_RESET;
    else if (wr_config)
      watchdog_config <= pwdata[7:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_state <= KEY_IDLE;
      delay_count <= '0;
      pulse_count <= '0;
    end
    else
    begin
      case (key_state)
        KEY_IDLE:
        begin
          delay_count <= '0;
          pulse_count <= '0;
          if (!key_valid)
            key_state <= KEY_WAIT;
        end
        KEY_WAIT:
        begin
          delay_count <= delay_count + 1'b1;
          if (delay_count == 16'(SOFT_DELAY - 1))
            key_state <= KEY_FIRE; // see RULE3
        end
        KEY_FIRE:
        begin
          pulse_count <= pulse_count + 1'b1;
          if (pulse_count == 3'(RESET_PULSE_CYCLES - 1))
            key_state <= KEY_IDLE;
        end
        default:
          key_state <= KEY_IDLE;
      endcase
    end
  end

  // Hardware set wins over a software clear; only a software zero write or rst_n (power-on) clears.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_cause_flags <= 8'h00;
    else if (fault_event)
      reset_cause_flags[KEY_FAULT_BIT] <= 1'b1; // see RULE4, see RULE13
    else if (wr_cause && !pwdata[KEY_FAULT_BIT])
      reset_cause_flags[KEY_FAULT_BIT] <= 1'b0; // see RULE5
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-speed tick and watchdog counter.
  logic [15:0] tick_count;
  logic tick_en;
  logic wdt_clear;
  logic expire;
  logic [1:0] low_power_sync;
  logic in_low_power;
  logic low_power_entry;
  logic low_power_prev;

  assign tick_en = (tick_count == 16'(TICK_CYCLES - 1));
  assign wdt_clear = bad_key_write || cpu_events.watchdog_clear_instr ||
                     cpu_events.halt_instr || low_power_entry; // see RULE9, see RULE12

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_count <= '0;
    else
      tick_count <= tick_en ? 16'h0000 : tick_count + 1'b1; // see RULE1
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_power_sync <= 2'b00;
      low_power_prev <= 1'b0;
    end
    else
    begin
      low_power_sync <= {low_power_sync[0], cpu_events.low_power};
      low_power_prev <= low_power_sync[1];
    end
  end

  assign in_low_power = low_power_sync[1];
  assign low_power_entry = in_low_power && !low_power_prev;

  wdt_ratio_counter #(
    .WIDTH(18)
  ) u_counter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick_en(tick_en),
    .run(key_enabled), // see RULE14
    .clear(wdt_clear),
    .timeout_select(timeout_select),
    .expire(expire)
  );

  ////////////////////////////////////////////////////////////////////////
  // Expiry actions and status flags.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      actions <= '0;
    else
    begin
      actions.device_reset <= (expire && !in_low_power) ||
                              (key_state == KEY_FIRE); // see RULE7, see RULE3
      actions.wake <= expire && in_low_power; // see RULE8
      actions.pc_sp_reset <= expire && in_low_power;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      watchdog_expiry_flag <= 1'b0;
    else if (expire)
      watchdog_expiry_flag <= 1'b1; // see RULE7, see RULE8
    else if (low_power_entry || cpu_events.halt_instr)
      watchdog_expiry_flag <= 1'b0; // see RULE12
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      powerdown_flag <= 1'b0;
    else if (cpu_events.halt_instr)
      powerdown_flag <= 1'b1; // see RULE10
    else if (cpu_events.watchdog_clear_instr)
      powerdown_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.
  logic [IRQ_BITS-1:0] irq_set;

  assign irq_set = {fault_event, expire && in_low_power, expire};
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
    end
    else
    begin
      irq_stat <= irq_set | (irq_stat & ~(wr_irq_stat ? pwdata[IRQ_BITS-1:0] : '0));
      if (wr_irq_mask)
        irq_mask <= pwdata[IRQ_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  AST_KEY_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE4
    fault_event |=> reset_cause_flags[KEY_FAULT_BIT])
    else $error("key fault flag not set");
  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE5
    (reset_cause_flags[0] && !(wr_cause && !pwdata[0])) |=> reset_cause_flags[0])
    else $error("key fault flag cleared by hardware");
  AST_BAD_KEY_RESET: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE3
    (key_state == KEY_WAIT && $past(key_state) == KEY_IDLE)
      |-> ##[1:1000] actions.device_reset)
    else $error("invalid key gave no reset");
  AST_RUN_RESET: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE7
    (expire && !in_low_power) |=> (actions.device_reset && watchdog_expiry_flag))
    else $error("expiry gave no reset");
  AST_SLEEP_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE8
    (expire && in_low_power) |=> (actions.wake && actions.pc_sp_reset))
    else $error("expiry in low power gave no wake");
  AST_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE14
    (watchdog_key_field == KEY_DISABLE) |-> !expire)
    else $error("expiry while disabled");
  AST_HALT_PD: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE10
    cpu_events.halt_instr |=> (powerdown_flag && !watchdog_expiry_flag))
    else $error("halt did not set power-down");
  AST_CLR_PD: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE10
    (cpu_events.watchdog_clear_instr && !cpu_events.halt_instr) |=> !powerdown_flag)
    else $error("clear did not drop power-down");
  AST_ENTRY_CLR: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE12
    low_power_entry |-> !expire)
    else $error("expiry on low-power entry");

endmodule : wdt_key_guard
`default_nettype wire

// ==== verilog/wdt_ratio_counter.sv ====
// Purpose: Watchdog count of low-speed ticks with a power-of-two timeout.
// Assumes: tick_en is a one-cycle enable at the low-speed rate.
// Notes: Clear has priority over counting.
`timescale 1ns/100ps
`default_nettype none
module wdt_ratio_counter #(
  parameter int unsigned WIDTH = 18
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick_en,
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] timeout_select,
  output logic expire
);
  import wdt_pkg::*;

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] limit;
  logic [4:0] shift;

  // Ratio per select code, see RULE2.
  assign shift = (timeout_select == 3'h0) ? 5'd8 :
                 (timeout_select == 3'h1) ? 5'd10 :
                 (timeout_select == 3'h2) ? 5'd12 :
                 (timeout_select == 3'h3) ? 5'd14 :
                 5'(5'd11 + 5'(timeout_select));
  assign limit = WIDTH'((64'd1 << shift) - 64'd1);
  assign expire = run && tick_en && !clear && (count == limit); // see RULE1

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (clear || !run || expire)
      count <= '0; // see RULE14
    else if (tick_en)
      count <= count + 1'b1;
  end

endmodule : wdt_ratio_counter
`default_nettype wire
